// ### core/nvm_ctrl_pkg.sv
// shared constants for the nvm erase/program controller
package nvm_ctrl_pkg;
  // register byte offsets
  localparam logic [11:0] OFF_SEL = 12'h000;
  localparam logic [11:0] OFF_MODE = 12'h004;
  localparam logic [11:0] OFF_OPCODE = 12'h008;
  localparam logic [11:0] OFF_PDONE = 12'h00c;
  localparam logic [11:0] OFF_DDONE = 12'h010;
  localparam logic [11:0] OFF_FLAGS = 12'h100;
  localparam logic [11:0] OFF_ECC = 12'h200;
  localparam logic [11:0] OFF_UNLOCK = 12'h204;
  localparam logic [11:0] OFF_PRANGE = 12'h208;
  localparam logic [11:0] OFF_DRANGE = 12'h20c;
  // register window base and span
  localparam logic [31:0] WIN_BASE = 32'h5000_0000;
  localparam logic [31:0] WIN_LAST = 32'h5000_ffff;
  // keys and codes
  localparam logic [15:0] KEY_PROG = 16'haa55;
  localparam logic [15:0] KEY_DATA = 16'hcd78;
  localparam logic [31:0] KEY_UNLOCK = 32'hab23_dc54;
  localparam logic [7:0] MODE_STALL = 8'ha5;
  localparam logic [7:0] MODE_PROG_BG = 8'h5a;
  localparam logic [7:0] MODE_DATA_BG = 8'h3c;
  localparam logic [7:0] OP_PAGE = 8'h55;
  localparam logic [7:0] OP_BLOCK = 8'haa;
  localparam logic [7:0] OP_WORD = 8'h33;
  localparam logic [7:0] OP_CONT = 8'hcc;
  // done/busy values and ecc reset value
  localparam logic [7:0] DONE_VAL = 8'h01;
  localparam logic [7:0] BUSY_VAL = 8'h00;
  localparam logic ECC_RST = 1'b1;
  // flag bit positions
  localparam int FL_PPROT = 0;
  localparam int FL_DPROT = 1;
  localparam int FL_PSBE = 2;
  localparam int FL_PMBE = 3;
  localparam int FL_DSBE = 4;
  localparam int FL_DMBE = 5;
  // address map of the arrays
  localparam logic [31:0] TRIM_LO = 32'h0001_8000;
  localparam logic [31:0] TRIM_HI = 32'h0001_8fff;
  localparam logic [31:0] PROG_BASE = 32'h0000_0000;
  localparam logic [31:0] PROG_PAGE_BYTES = 32'h0000_0800;
  localparam logic [31:0] USR_LO = 32'h4000_0800;
  localparam logic [31:0] USR_HI = 32'h4000_08ff;
  localparam logic [31:0] DATA_BASE = 32'h4000_0000;
  localparam logic [31:0] DATA_PAGE_BYTES = 32'h0000_0040;
  // timing, in ns and in clock cycles
  localparam int CLK_NS = 8;
  localparam int DWRITE_MIN_NS = 16000;
  localparam int DERASE_MIN_NS = 16000000;
  localparam int DWRITE_CYC = (DWRITE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int DERASE_CYC = (DERASE_MIN_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ### core/nvm_erase_program_controller.sv
// erase/program sequencer for the program flash and data eeprom
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module nvm_erase_program_controller #(
  parameter int DWRITE_CYCLES = nvm_ctrl_pkg::DWRITE_CYC,
  parameter int DERASE_CYCLES = nvm_ctrl_pkg::DERASE_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // erase/program request from the cpu data path
  input wire logic nvm_req,
  input wire logic [31:0] nvm_addr,
  // program flash macro
  output logic prog_start,
  output logic [7:0] prog_op,
  output logic [31:0] prog_addr,
  output logic prog_erase_main,
  output logic prog_erase_special,
  input wire logic prog_macro_done,
  output logic cpu_stall,
  // data eeprom macro
  output logic data_start,
  output logic [7:0] data_op,
  output logic [31:0] data_addr,
  output logic data_erase_main,
  output logic data_erase_special,
  // ecc engine
  output logic ecc_enable,
  input wire logic prog_sbe,
  input wire logic prog_mbe,
  input wire logic data_sbe,
  input wire logic data_mbe
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PROG = 2'b01,
    ST_DATA = 2'b10
  } phase_t;

  typedef struct packed {
    phase_t phase;
    logic [15:0] sel;
    logic [7:0] mode;
    logic [7:0] opcode;
    logic [7:0] pdone;
    logic [7:0] ddone;
    logic ecc;
    logic [31:0] unlock;
    logic [7:0] prange;
    logic [7:0] drange;
    logic [5:0] flags;
    logic [31:0] timer;
    logic [31:0] rdata;
    logic start;
    logic [31:0] addr;
    logic emain;
    logic espec;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  // address inside the eeprom user special area
  function automatic logic in_user_area(input logic [31:0] a);
    in_user_area = a >= nvm_ctrl_pkg::USR_LO &&
      a <= nvm_ctrl_pkg::USR_HI;
  endfunction

  // is address protected on the selected array
  function automatic logic is_protected(input logic to_data,
    input logic [31:0] a, input logic [7:0] prange, input logic [7:0] drange);
    logic [31:0] lim;
    lim = 32'h0;
    if (!to_data)
    begin
      lim = nvm_ctrl_pkg::PROG_BASE + 32'(prange) *
        nvm_ctrl_pkg::PROG_PAGE_BYTES;
      is_protected = (a >= nvm_ctrl_pkg::TRIM_LO &&
        a <= nvm_ctrl_pkg::TRIM_HI) ||
        (a < lim);
    end
    else
    begin
      lim = nvm_ctrl_pkg::DATA_BASE + 32'(drange) *
        nvm_ctrl_pkg::DATA_PAGE_BYTES;
      is_protected = (drange != 8'h00) &&
        (in_user_area(a) ||
        (a >= nvm_ctrl_pkg::DATA_BASE && a < lim));
    end
  endfunction

  logic in_win;
  logic mapped;
  logic [11:0] off;
  logic acc;
  logic wr;
  logic sel_prog;
  logic sel_data;
  logic op_ok;
  logic hit_prot;
  logic in_special;
  logic cyc_done;
  logic [31:0] dur;

  assign in_win = paddr >= nvm_ctrl_pkg::WIN_BASE &&
    paddr <= nvm_ctrl_pkg::WIN_LAST;
  assign off = paddr[11:0];
  assign acc = psel && penable;
  assign mapped = in_win && paddr[15:12] == 4'h0;
  assign wr = acc && pwrite && mapped;
  assign sel_prog = st_ff.sel == nvm_ctrl_pkg::KEY_PROG;
  assign sel_data = st_ff.sel == nvm_ctrl_pkg::KEY_DATA;

  // operation legal for mode, opcode and selected array
  always_comb
  begin
    op_ok = 1'b0;
    if (sel_prog && (st_ff.mode == nvm_ctrl_pkg::MODE_STALL ||
      st_ff.mode == nvm_ctrl_pkg::MODE_PROG_BG))
      op_ok = 1'b1;
    if (sel_data && st_ff.mode == nvm_ctrl_pkg::MODE_DATA_BG)
      op_ok = 1'b1;
    if (st_ff.opcode != nvm_ctrl_pkg::OP_PAGE &&
      st_ff.opcode != nvm_ctrl_pkg::OP_BLOCK &&
      st_ff.opcode != nvm_ctrl_pkg::OP_WORD &&
      st_ff.opcode != nvm_ctrl_pkg::OP_CONT)
      op_ok = 1'b0;
    if (st_ff.mode == nvm_ctrl_pkg::MODE_STALL &&
      st_ff.opcode == nvm_ctrl_pkg::OP_BLOCK)
      op_ok = 1'b0;
  end

  assign hit_prot = is_protected(sel_data, nvm_addr, st_ff.prange,
    st_ff.drange);
  assign in_special = sel_data &&
    in_user_area(nvm_addr);
  // eeprom word write vs erase duration
  assign dur = (st_ff.opcode == nvm_ctrl_pkg::OP_WORD ||
    st_ff.opcode == nvm_ctrl_pkg::OP_CONT) ?
    32'(DWRITE_CYCLES) : 32'(DERASE_CYCLES);
  assign cyc_done = (st_ff.phase == ST_PROG && prog_macro_done) ||
    (st_ff.phase == ST_DATA && st_ff.timer == 32'h1);

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.start = 1'b0;
    // register writes
    if (wr && st_ff.phase == ST_IDLE)
    begin
      unique case (off)
        nvm_ctrl_pkg::OFF_SEL: nxt_st.sel = pwdata[15:0];
        nvm_ctrl_pkg::OFF_MODE:
          if (sel_prog || sel_data)
            nxt_st.mode = pwdata[7:0];
        nvm_ctrl_pkg::OFF_OPCODE:
          if ((sel_prog || sel_data) && !(st_ff.mode ==
            nvm_ctrl_pkg::MODE_STALL && pwdata[7:0] ==
            nvm_ctrl_pkg::OP_BLOCK))
            nxt_st.opcode = pwdata[7:0];
        default: ;
      endcase
    end
    if (wr)
    begin
      unique case (off)
        nvm_ctrl_pkg::OFF_ECC: nxt_st.ecc = pwdata[0];
        nvm_ctrl_pkg::OFF_UNLOCK: nxt_st.unlock = pwdata;
        nvm_ctrl_pkg::OFF_PRANGE:
          if (st_ff.unlock == nvm_ctrl_pkg::KEY_UNLOCK)
          begin
            nxt_st.prange = pwdata[7:0];
            nxt_st.unlock = 32'h0;
          end
        nvm_ctrl_pkg::OFF_DRANGE:
          if (st_ff.unlock == nvm_ctrl_pkg::KEY_UNLOCK)
          begin
            nxt_st.drange = pwdata[7:0];
            nxt_st.unlock = 32'h0;
          end
        nvm_ctrl_pkg::OFF_FLAGS:
          nxt_st.flags = st_ff.flags & ~pwdata[5:0];
        default: ;
      endcase
    end
    // error events win over a same-cycle clear
    if (st_ff.ecc)
    begin
      nxt_st.flags[nvm_ctrl_pkg::FL_PSBE] =
        nxt_st.flags[nvm_ctrl_pkg::FL_PSBE] | prog_sbe;
      nxt_st.flags[nvm_ctrl_pkg::FL_PMBE] =
        nxt_st.flags[nvm_ctrl_pkg::FL_PMBE] | prog_mbe;
      nxt_st.flags[nvm_ctrl_pkg::FL_DSBE] =
        nxt_st.flags[nvm_ctrl_pkg::FL_DSBE] | data_sbe;
      nxt_st.flags[nvm_ctrl_pkg::FL_DMBE] =
        nxt_st.flags[nvm_ctrl_pkg::FL_DMBE] | data_mbe;
    end
    unique case (st_ff.phase)
      ST_IDLE:
        // one sequencer serves both arrays, so they never overlap
        if (nvm_req && op_ok)
        begin
          if (hit_prot)
          begin
            if (sel_data)
              nxt_st.flags[nvm_ctrl_pkg::FL_DPROT] = 1'b1;
            else
              nxt_st.flags[nvm_ctrl_pkg::FL_PPROT] = 1'b1;
            // suppressed attempt still ends the sequence
            nxt_st.sel = 16'h0;
            nxt_st.mode = 8'h00;
            nxt_st.opcode = 8'h00;
          end
          else
          begin
            nxt_st.start = 1'b1;
            nxt_st.addr = nvm_addr;
            // page erase works on the whole page holding the address
            if (st_ff.opcode == nvm_ctrl_pkg::OP_PAGE)
              nxt_st.addr = nvm_addr & ~((sel_data ?
                nvm_ctrl_pkg::DATA_PAGE_BYTES :
                nvm_ctrl_pkg::PROG_PAGE_BYTES) - 32'h1);
            nxt_st.emain = st_ff.opcode == nvm_ctrl_pkg::OP_BLOCK;
            nxt_st.espec = st_ff.opcode == nvm_ctrl_pkg::OP_BLOCK &&
              in_special;
            if (sel_data)
            begin
              nxt_st.phase = ST_DATA;
              nxt_st.ddone = nvm_ctrl_pkg::BUSY_VAL;
              nxt_st.timer = dur;
            end
            else
            begin
              nxt_st.phase = ST_PROG;
              nxt_st.pdone = nvm_ctrl_pkg::BUSY_VAL;
            end
          end
        end
      ST_PROG, ST_DATA:
      begin
        if (st_ff.timer != 32'h0)
          nxt_st.timer = st_ff.timer - 32'h1;
        if (cyc_done)
        begin
          nxt_st.phase = ST_IDLE;
          nxt_st.sel = 16'h0;
          nxt_st.mode = 8'h00;
          nxt_st.opcode = 8'h00;
          if (st_ff.phase == ST_PROG)
            nxt_st.pdone = nvm_ctrl_pkg::DONE_VAL;
          else
            nxt_st.ddone = nvm_ctrl_pkg::DONE_VAL;
        end
      end
      default: nxt_st.phase = ST_IDLE;
    endcase
    // read data
    nxt_st.rdata = 32'h0;
    if (psel && !penable && !pwrite)
    begin
      unique case (off)
        nvm_ctrl_pkg::OFF_SEL: nxt_st.rdata = {16'h0, st_ff.sel};
        nvm_ctrl_pkg::OFF_MODE: nxt_st.rdata = {24'h0, st_ff.mode};
        nvm_ctrl_pkg::OFF_OPCODE: nxt_st.rdata = {24'h0, st_ff.opcode};
        nvm_ctrl_pkg::OFF_PDONE: nxt_st.rdata = {24'h0, st_ff.pdone};
        nvm_ctrl_pkg::OFF_DDONE: nxt_st.rdata = {24'h0, st_ff.ddone};
        nvm_ctrl_pkg::OFF_FLAGS: nxt_st.rdata = {26'h0, st_ff.flags};
        nvm_ctrl_pkg::OFF_ECC: nxt_st.rdata = {31'h0, st_ff.ecc};
        nvm_ctrl_pkg::OFF_UNLOCK: nxt_st.rdata = st_ff.unlock;
        nvm_ctrl_pkg::OFF_PRANGE: nxt_st.rdata = {24'h0, st_ff.prange};
        nvm_ctrl_pkg::OFF_DRANGE: nxt_st.rdata = {24'h0, st_ff.drange};
        default: nxt_st.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '0;
      st_ff.phase <= ST_IDLE;
      st_ff.pdone <= nvm_ctrl_pkg::DONE_VAL;
      st_ff.ddone <= nvm_ctrl_pkg::DONE_VAL;
      st_ff.ecc <= nvm_ctrl_pkg::ECC_RST;
    end
    else
      st_ff <= nxt_st;
  end

  // every access ends in one access cycle
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata = st_ff.rdata;

  assign prog_start = st_ff.start && st_ff.phase == ST_PROG;
  assign data_start = st_ff.start && st_ff.phase == ST_DATA;
  assign prog_op = st_ff.phase == ST_PROG ? st_ff.opcode : 8'h00;
  assign data_op = st_ff.phase == ST_DATA ? st_ff.opcode : 8'h00;
  assign prog_addr = st_ff.addr;
  assign data_addr = st_ff.addr;
  // flash special area is trim data and is never erased
  assign prog_erase_main = st_ff.phase == ST_PROG && st_ff.emain;
  assign prog_erase_special = 1'b0;
  assign data_erase_main = st_ff.phase == ST_DATA && st_ff.emain;
  assign data_erase_special = st_ff.phase == ST_DATA && st_ff.espec;
  assign cpu_stall = st_ff.phase == ST_PROG &&
    st_ff.mode == nvm_ctrl_pkg::MODE_STALL;
  assign ecc_enable = st_ff.ecc;
endmodule

// ### verification/flash_macro_model.sv
// behavioural program flash macro answering start with a done pulse
`timescale 1ns/1ps
module flash_macro_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // macro handshake
  input wire logic prog_start,
  input wire logic slow,
  output logic prog_macro_done
);
  int cnt;
  // slow stands in for a long erase, prompt for a short word write
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 0;
      prog_macro_done <= 1'b0;
    end
    else
    begin
      prog_macro_done <= (cnt == 1);
      if (prog_start)
        cnt <= slow ? 40 : 3;
      else if (cnt != 0)
        cnt <= cnt - 1;
    end
  end
endmodule

// ### verification/nvm_ctrl_chk.sv
// pin-level assertions for the erase/program controller
`timescale 1ns/1ps
module nvm_ctrl_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] paddr,
  input wire logic pslverr,
  // sequencer
  input wire logic prog_start,
  input wire logic [7:0] prog_op,
  input wire logic [31:0] prog_addr,
  input wire logic prog_erase_special,
  input wire logic cpu_stall,
  input wire logic data_start,
  input wire logic data_erase_main,
  input wire logic data_erase_special,
  input wire logic ecc_enable
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_pulse;
    prog_start ##1 !prog_start;
  endsequence
  a_start_pulse: assert property (prog_start |-> s_pulse)
    else $error("flash start held longer than one cycle");
  a_one_array: assert property (!(prog_start && data_start))
    else $error("both arrays started together");
  a_trim_safe: assert property (prog_start |->
    !(prog_addr inside {[nvm_ctrl_pkg::TRIM_LO:nvm_ctrl_pkg::TRIM_HI]}))
    else $error("trimming area operation launched");
  a_trim_scope: assert property (!prog_erase_special)
    else $error("flash special area erase requested");
  a_data_scope: assert property (data_erase_special |-> data_erase_main)
    else $error("special erase without main erase");
  a_stall_block: assert property (cpu_stall |->
    prog_op != nvm_ctrl_pkg::OP_BLOCK) else $error("block erase while stalled");
  a_stall_busy: assert property (cpu_stall |-> prog_op != 8'h00)
    else $error("stall without flash operation");
  a_ecc_reset: assert property ($rose(rst_n) |-> ecc_enable)
    else $error("ecc disabled out of reset");
  a_window_err: assert property (psel && penable &&
    paddr[31:16] != 16'h5000 |-> pslverr) else $error("no error off window");
endmodule
bind nvm_erase_program_controller nvm_ctrl_chk u_chk (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .psel(psel),
  .penable(penable),
  .paddr(paddr),
  .pslverr(pslverr),
  .prog_start(prog_start),
  .prog_op(prog_op),
  .prog_addr(prog_addr),
  .prog_erase_special(prog_erase_special),
  .cpu_stall(cpu_stall),
  .data_start(data_start),
  .data_erase_main(data_erase_main),
  .data_erase_special(data_erase_special),
  .ecc_enable(ecc_enable)
);

// ### verification/tb_top.sv
// self-checking bench for the erase/program controller
`timescale 1ns/1ps
module tb_top;
  localparam int DW = 20;
  localparam int DE = 50;
  localparam logic [31:0] B = nvm_ctrl_pkg::WIN_BASE;
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, nvm_addr, rd, prog_addr, data_addr, sa;
  logic [7:0] prog_op, data_op, seen;
  logic nvm_req, prog_start, prog_erase_main, prog_erase_special, slow;
  logic prog_macro_done, cpu_stall, data_start, data_erase_main;
  logic data_erase_special, ecc_enable, prog_sbe, prog_mbe, data_sbe;
  logic data_mbe, em, es;
  int fail_count, check_count, nstart, nbusy, nstall;
  logic [11:0] offs[9] = '{12'h0, 12'h4, 12'h8, 12'hc, 12'h10, 12'h200,
    12'h204, 12'h208, 12'h20c};
  int rsts[9] = '{0, 0, 0, 1, 1, 1, 0, 0, 0};
  logic [7:0] ops[4] = '{8'h33, 8'hcc, 8'h55, 8'haa};
  nvm_erase_program_controller #(.DWRITE_CYCLES(DW), .DERASE_CYCLES(DE))
    DUT (.*);
  flash_macro_model partner (.*);
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    nstart += int'(prog_start) + int'(data_start);
    nbusy += int'(data_op != 8'h00);
    nstall += int'(cpu_stall);
    if ((prog_op | data_op) != 8'h00)
      seen = prog_op | data_op;
    if (prog_start || data_start)
      sa = prog_start ? prog_addr : data_addr;
    em |= prog_erase_main | data_erase_main;
    es |= prog_erase_special | data_erase_special;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] off, input logic [31:0] d);
    apb(1'b1, B + 32'(off), d);
  endtask
  task rdc(input logic [11:0] off, input logic [31:0] exp);
    apb(1'b0, B + 32'(off), 32'h0);
    chk(rd, exp);
  endtask
  // go: launch expected; len: eeprom busy cycles, 0 to skip
  task run_op(input logic [15:0] sel, input logic [7:0] md,
    input logic [7:0] op, input logic [31:0] a, input int go, input int len);
    logic [11:0] dn;
    logic [31:0] fl;
    logic [31:0] pg;
    logic [31:0] ea;
    logic xs;
    int w;
    dn = sel == nvm_ctrl_pkg::KEY_PROG ? 12'h00c : 12'h010;
    pg = sel == nvm_ctrl_pkg::KEY_PROG ? nvm_ctrl_pkg::PROG_PAGE_BYTES :
      nvm_ctrl_pkg::DATA_PAGE_BYTES;
    ea = op == nvm_ctrl_pkg::OP_PAGE ? a & ~(pg - 32'h1) : a;
    xs = op == nvm_ctrl_pkg::OP_BLOCK && sel == nvm_ctrl_pkg::KEY_DATA &&
      a >= nvm_ctrl_pkg::USR_LO && a <= nvm_ctrl_pkg::USR_HI;
    fl = sel == nvm_ctrl_pkg::KEY_PROG ? 32'h1 : 32'h2;
    wr(nvm_ctrl_pkg::OFF_SEL, {16'h0000, sel});
    wr(nvm_ctrl_pkg::OFF_MODE, {24'h0, md});
    wr(nvm_ctrl_pkg::OFF_OPCODE, {24'h0, op});
    @(posedge core_clk);
    nstart = 0;
    nbusy = 0;
    nstall = 0;
    seen = 8'h00;
    sa = 32'h0;
    em = 1'b0;
    es = 1'b0;
    nvm_req <= 1'b1;
    nvm_addr <= a;
    @(posedge core_clk);
    nvm_req <= 1'b0;
    rdc(dn, go ? 32'h0 : 32'h1);
    w = 0;
    while (w < 300 && (prog_op | data_op) != 8'h00)
    begin
      @(posedge core_clk);
      w++;
    end
    chk(32'(w < 300), 32'h1);
    @(posedge core_clk);
    chk(nstart, go);
    chk({24'h0, seen}, go ? {24'h0, op} : 32'h0);
    chk(32'(nstall > 0), 32'(go != 0 && md == 8'ha5));
    if (go != 0)
      chk(sa, ea);
    chk(32'(em), 32'(go != 0 && op == nvm_ctrl_pkg::OP_BLOCK));
    chk(32'(es), 32'(go != 0 && xs));
    if (len > 0) chk(nbusy, len);
    rdc(nvm_ctrl_pkg::OFF_SEL, 32'h0);
    rdc(nvm_ctrl_pkg::OFF_MODE, 32'h0);
    rdc(nvm_ctrl_pkg::OFF_OPCODE, 32'h0);
    rdc(dn, 32'h1);
    rdc(nvm_ctrl_pkg::OFF_FLAGS, go ? 32'h0 : fl);
    wr(nvm_ctrl_pkg::OFF_FLAGS, 32'h3);
  endtask
  task tally_and_finish();
    $display("checks=%0d errors=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #400000;
    fail_count++;
    tally_and_finish();
  end
  initial
  begin
    {rst_n, psel, penable, pwrite, nvm_req, slow} = 6'h01;
    {paddr, pwdata, nvm_addr} = 96'h0;
    {data_mbe, data_sbe, prog_mbe, prog_sbe} = 4'h0;
    void'($urandom(19));
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (offs[i]) rdc(offs[i], rsts[i]);
    rdc(12'h040, 32'h0);
    apb(1'b0, 32'h6000_0000, 32'h0);
    chk(32'(err), 32'h1);
    wr(nvm_ctrl_pkg::OFF_SEL, $urandom % 32'h8000);
    wr(nvm_ctrl_pkg::OFF_MODE, 32'h3c);
    rdc(nvm_ctrl_pkg::OFF_MODE, 32'h0);
    // aligned whole words only, inside the unprotected data space
    for (int i = 0; i < 4; i++) run_op(16'hcd78, 8'h3c, ops[i],
      32'h4000_0400 + 4 * ($urandom % 64), 1, i < 2 ? DW : DE);
    run_op(16'hcd78, 8'h3c, 8'haa, nvm_ctrl_pkg::USR_LO, 1, DE);
    wr(nvm_ctrl_pkg::OFF_SEL, 32'haa55);
    wr(nvm_ctrl_pkg::OFF_MODE, 32'ha5);
    wr(nvm_ctrl_pkg::OFF_OPCODE, 32'haa);
    rdc(nvm_ctrl_pkg::OFF_OPCODE, 32'h0);
    run_op(16'haa55, 8'ha5, 8'h55,
      32'h0000_2000 + 4 * ($urandom % 512), 1, 0);
    slow <= 1'b0;
    run_op(16'haa55, 8'h5a, 8'hcc, 32'h0000_3000, 1, 0);
    run_op(16'haa55, 8'h5a, 8'haa, 32'h0000_4000, 1, 0);
    slow <= 1'b1;
    wr(nvm_ctrl_pkg::OFF_UNLOCK, $urandom % 32'h1000_0000);
    wr(nvm_ctrl_pkg::OFF_PRANGE, 32'h2);
    rdc(nvm_ctrl_pkg::OFF_PRANGE, 32'h0);
    wr(nvm_ctrl_pkg::OFF_UNLOCK, nvm_ctrl_pkg::KEY_UNLOCK);
    wr(nvm_ctrl_pkg::OFF_PRANGE, 32'h2);
    rdc(nvm_ctrl_pkg::OFF_PRANGE, 32'h2);
    rdc(nvm_ctrl_pkg::OFF_UNLOCK, 32'h0);
    run_op(16'haa55, 8'h5a, 8'h33, 32'h0000_0ffc, 0, 0);
    run_op(16'haa55, 8'h5a, 8'h33, 32'h0000_1000, 1, 0);
    run_op(16'haa55, 8'h5a, 8'h55, nvm_ctrl_pkg::TRIM_LO, 0, 0);
    wr(nvm_ctrl_pkg::OFF_UNLOCK, nvm_ctrl_pkg::KEY_UNLOCK);
    wr(nvm_ctrl_pkg::OFF_DRANGE, 32'h1);
    run_op(16'hcd78, 8'h3c, 8'h33, 32'h4000_003c, 0, 0);
    run_op(16'hcd78, 8'h3c, 8'h33, nvm_ctrl_pkg::USR_HI - 3, 0, 0);
    run_op(16'hcd78, 8'h3c, 8'h33, 32'h4000_0040, 1, DW);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge core_clk);
      if (i == 4)
        wr(nvm_ctrl_pkg::OFF_ECC, 32'h0);
      {data_mbe, data_sbe, prog_mbe, prog_sbe} <= i < 4 ? 4'(1 << i) : 4'hf;
      @(posedge core_clk);
      {data_mbe, data_sbe, prog_mbe, prog_sbe} <= 4'h0;
      rdc(nvm_ctrl_pkg::OFF_FLAGS, i < 4 ? 32'(1 << (i + 2)) : 32'h0);
      wr(nvm_ctrl_pkg::OFF_FLAGS, 32'h3c);
    end
    chk(32'(ecc_enable), 32'h0);
    tally_and_finish();
  end
endmodule
